// ==== core/pllpd_pkg.sv ====
// Purpose: Shared constants and types of the clock-mode and power-down control block
// Assumes: 100 MHz system clock, AXI4-Lite register access with 8-bit byte addresses
// Notes: Every register offset, field position, code and cycle count used by the design lives here
package pllpd_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned LOCK_TYP_NS = 75000;
  localparam int unsigned LOCK_EXTRA_PCT = 150;
  localparam int unsigned LOCK_MAX_NS = LOCK_TYP_NS * (100 + LOCK_EXTRA_PCT) / 100;
  localparam int unsigned LOCK_CYCLES = (LOCK_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PD1_DELAY_CYCLES = 8;
  localparam logic [2:0] PD1_CNT_LAST = 3'(PD1_DELAY_CYCLES - 1);

  // ****************************************
  // Register map and bus answers
  // ****************************************
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] ADDR_CONTROL_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CLOCK_STATUS = 8'h04;
  localparam logic [7:0] ADDR_BOOT_WORD = 8'h08;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int unsigned FIELD_STRB_LANE = 1;

  // ****************************************
  // Power-down select field
  // ****************************************
  localparam int unsigned PD_LSB = 10;
  localparam int unsigned PD_MSB = 15;
  localparam logic [5:0] PD_CODE_NONE = 6'h00;
  localparam logic [5:0] PD_CODE_HALT_EN = 6'h09;
  localparam logic [5:0] PD_CODE_HALT_ANY = 6'h11;
  localparam logic [5:0] PD_CODE_PLL_OUT = 6'h1A;
  localparam logic [5:0] PD_CODE_PLL_IN = 6'h1C;

  // ****************************************
  // Boot word and clock status layout
  // ****************************************
  localparam int unsigned BOOT_CFG2_BIT = 31;
  localparam int unsigned BOOT_CFG1_BIT = 27;
  localparam int unsigned BOOT_CFG0_BIT = 23;
  localparam int unsigned ST_BYPASS = 4;
  localparam int unsigned ST_LOCKED = 5;
  localparam int unsigned ST_CPU_HALT = 6;
  localparam int unsigned ST_PLL_OUT = 7;
  localparam int unsigned ST_PLL_IN = 8;
  localparam int unsigned ST_STRAP = 9;
  localparam logic [2:0] CFG_BYPASS = 3'h0;
  localparam logic [3:0] MULT_X1 = 4'h1;
  localparam logic [3:0] MULT_X10 = 4'hA;

  typedef enum logic [2:0] {PD_RUN, PD_ARM, PD_CPU_HALT, PD_PLL_OUT, PD_PLL_IN} pllpd_state_e;

  function automatic logic [3:0] pllpd_mult(input logic [2:0] cfg);
    case (cfg)
      3'h1: pllpd_mult = 4'h4;
      3'h2: pllpd_mult = 4'h8;
      3'h3: pllpd_mult = 4'hA;
      3'h4: pllpd_mult = 4'h6;
      3'h5: pllpd_mult = 4'h9;
      3'h6: pllpd_mult = 4'h7;
      3'h7: pllpd_mult = 4'hB;
      default: pllpd_mult = MULT_X1;
    endcase
  endfunction

endpackage

// ==== core/pllpd_lock_if.sv ====
// Purpose: Carries the lock wait request and its answer between controller and timer
// Assumes: Both ends on clk_sys
// Notes: hold is a level; locked rises a fixed number of cycles after hold falls
`timescale 1ns/1ps
interface pllpd_lock_if;
  logic hold;
  logic locked;
  modport timer (input hold, output locked);
  modport ctrl (output hold, input locked);
endinterface

// ==== core/pllpd_lock_timer.sv ====
// Purpose: Waits out the worst-case PLL lock interval
// Assumes: hold high restarts the wait
// Notes: Wait length is a parameter so simulation can shorten it
`timescale 1ns/1ps
module pllpd_lock_timer #(
  parameter int unsigned LOCK_WAIT_CYCLES = pllpd_pkg::LOCK_CYCLES
) (
  // Clocking
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic clk_en,
  // Controller side
  pllpd_lock_if.timer lock
);

  localparam int unsigned CW = $clog2(LOCK_WAIT_CYCLES + 1);
  localparam logic [CW-1:0] CNT_LOAD = CW'(LOCK_WAIT_CYCLES - 1);

  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic busy_ff;
  logic nxt_busy;
  logic locked_ff;
  logic nxt_locked;

  // ****************************************
  // Lock wait
  // ****************************************
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_busy = busy_ff;
    nxt_locked = locked_ff;
    if (lock.hold) begin
      nxt_cnt = CNT_LOAD;
      nxt_busy = 1'b1;
      nxt_locked = 1'b0;
    end else if (busy_ff) begin
      if (cnt_ff == '0) begin
        nxt_busy = 1'b0;
        nxt_locked = 1'b1;
      end else begin
        nxt_cnt = cnt_ff - CW'(1);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= '0;
      busy_ff <= 1'b0;
      locked_ff <= 1'b0;
    end else if (clk_en) begin
      cnt_ff <= nxt_cnt;
      busy_ff <= nxt_busy;
      locked_ff <= nxt_locked;
    end
  end

  assign lock.locked = locked_ff;

  AST_LOCK_CLEARED: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (lock.hold && clk_en) |=> !locked_ff)
    else $error("lock flag survived a restart");

  AST_LOCK_AT_END: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (busy_ff && !lock.hold && cnt_ff == '0 && clk_en) |=> (locked_ff && !busy_ff))
    else $error("lock not reported at end of wait");

endmodule

// ==== core/pllpd_top.sv ====
// Purpose: Clock mode selection from boot straps and power-down mode control
// Assumes: clk_sys stands in for the CPU clock; pins arrive asynchronously
// Notes: Clock outputs are run levels and a divided toggle, not analog PLL clocks
//
// Contract
// - With the enable strap low the PLL is bypassed at x1 and the config bits are ignored.
// - With the strap high the PLL is used unless all three config bits were zero at reset.
// - Config bits decode 000 bypass, 001 x4, 010 x8, 011 x10, 100 x6, 101 x9, 110 x7, 111 x11.
// - Config bits come from data bus bits 31, 27 and 23, captured with the boot word in reset.
// - Lock waiting allows the typical lock time plus 150 percent.
// - Power-down mode and wake method come from bits 15 to 10 of the control/status register.
// - Field codes: none, halt on enabled irq, halt on any irq, PLL output halt, PLL input halt.
// - CPU halt takes effect eight to nine cycles after the field is written.
// - PLL output and input halt end only on device reset.
`timescale 1ns/1ps
module pllpd_top #(
  parameter int unsigned LOCK_WAIT_CYCLES = pllpd_pkg::LOCK_CYCLES
) (
  // Clocking
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic clk_en,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins
  input wire logic pll_enable_strap,
  input wire logic device_reset_n,
  input wire logic [31:0] external_data_bus,
  // Wake requests from the interrupt logic
  input wire logic irq_enabled_wake,
  input wire logic irq_any_wake,
  // Clock and mode outputs
  output logic cpu_clock_output,
  output logic half_rate_clock_output,
  output logic [3:0] pll_multiply_factor,
  output logic pll_bypass,
  output logic cpu_halt_mode,
  output logic pll_output_halt_mode,
  output logic pll_input_halt_mode
);

  localparam int unsigned PIN_W = 34;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] s1_ff;
  logic [PIN_W-1:0] s2_ff;
  logic [PIN_W-1:0] s3_ff;
  logic [PIN_W-1:0] st_ff;
  logic [PIN_W-1:0] nxt_st;

  assign pin_raw = {pll_enable_strap, device_reset_n, external_data_bus};

  // A change counts only once the second and third stages agree
  for (genvar i = 0; i < PIN_W; i++) begin : g_sync
    always_comb begin
      nxt_st[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : st_ff[i];
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
        s1_ff[i] <= 1'b0;
        s2_ff[i] <= 1'b0;
        s3_ff[i] <= 1'b0;
        st_ff[i] <= 1'b0;
      end else if (clk_en) begin
        s1_ff[i] <= pin_raw[i];
        s2_ff[i] <= s1_ff[i];
        s3_ff[i] <= s2_ff[i];
        st_ff[i] <= nxt_st[i];
      end
    end
  end

  logic strap_st;
  logic dev_rst_n_st;
  logic [31:0] bus_st;
  logic [2:0] bus_cfg;
  assign strap_st = st_ff[PIN_W-1];
  assign dev_rst_n_st = st_ff[PIN_W-2];
  assign bus_st = st_ff[31:0];
  assign bus_cfg = {bus_st[pllpd_pkg::BOOT_CFG2_BIT], bus_st[pllpd_pkg::BOOT_CFG1_BIT],
                    bus_st[pllpd_pkg::BOOT_CFG0_BIT]};

  // ****************************************
  // Boot capture and clock mode
  // ****************************************
  logic [31:0] boot_ff;
  logic [31:0] nxt_boot;
  logic strap_ff;
  logic nxt_strap;
  logic bypass_ff;
  logic nxt_bypass;
  logic [3:0] factor_ff;
  logic [3:0] nxt_factor;

  always_comb begin
    nxt_boot = boot_ff;
    nxt_strap = strap_ff;
    nxt_bypass = bypass_ff;
    nxt_factor = factor_ff;
    if (!dev_rst_n_st) begin
      nxt_boot = bus_st;
      nxt_strap = strap_st;
      nxt_bypass = !strap_st || (bus_cfg == pllpd_pkg::CFG_BYPASS);
      nxt_factor = strap_st ? pllpd_pkg::pllpd_mult(bus_cfg) : pllpd_pkg::MULT_X1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      boot_ff <= '0;
      strap_ff <= 1'b0;
      bypass_ff <= 1'b1;
      factor_ff <= pllpd_pkg::MULT_X1;
    end else if (clk_en) begin
      boot_ff <= nxt_boot;
      strap_ff <= nxt_strap;
      bypass_ff <= nxt_bypass;
      factor_ff <= nxt_factor;
    end
  end

  // Device reset or bypass holds the wait; a new reset edge restarts lock unless the PLL is bypassed
  pllpd_lock_if lock_if ();
  assign lock_if.hold = !dev_rst_n_st || bypass_ff;

  pllpd_lock_timer #(.LOCK_WAIT_CYCLES(LOCK_WAIT_CYCLES)) u_lock (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .lock(lock_if.timer)
  );

  logic clk_ready;
  assign clk_ready = dev_rst_n_st && (bypass_ff || lock_if.locked);

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  logic bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid, wr_go, csr_wr, cpu_run, half_ff, nxt_half;
  logic wake_any_ff, nxt_wake_any;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata, status_word;
  logic [5:0] field_ff, nxt_field, wr_field;
  logic [2:0] arm_cnt_ff, nxt_arm_cnt;
  pllpd_pkg::pllpd_state_e pd_ff, nxt_pd;

  // Both write channels are taken at one edge; no skid storage is kept for a lone channel
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = !rvalid_ff;
  assign wr_field = s_axi_wdata[pllpd_pkg::PD_MSB:pllpd_pkg::PD_LSB];
  // One byte lane holds the whole field, so its six bits always land together
  assign csr_wr = wr_go && (s_axi_awaddr == pllpd_pkg::ADDR_CONTROL_STATUS)
                  && s_axi_wstrb[pllpd_pkg::FIELD_STRB_LANE];
  // Packed from bit 0 up in the order of the status bit positions
  assign status_word = 32'({strap_ff, pll_input_halt_mode, pll_output_halt_mode, cpu_halt_mode,
                            lock_if.locked, bypass_ff, factor_ff});
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;

  always_comb begin
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rresp = rresp_ff;
    nxt_rdata = rdata_ff;
    nxt_field = field_ff;
    if (wr_go) begin
      nxt_bvalid = 1'b1;
      // Status and boot word are read-only
      nxt_bresp = (s_axi_awaddr == pllpd_pkg::ADDR_CONTROL_STATUS) ? pllpd_pkg::RESP_OKAY : pllpd_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    if (!dev_rst_n_st) nxt_field = pllpd_pkg::PD_CODE_NONE;
    else if (csr_wr) nxt_field = wr_field;
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = pllpd_pkg::RESP_OKAY;
      case (s_axi_araddr)
        pllpd_pkg::ADDR_CONTROL_STATUS: nxt_rdata = 32'(field_ff) << pllpd_pkg::PD_LSB;
        pllpd_pkg::ADDR_CLOCK_STATUS: nxt_rdata = status_word;
        pllpd_pkg::ADDR_BOOT_WORD: nxt_rdata = boot_ff;
        default: begin
          nxt_rdata = '0;
          nxt_rresp = pllpd_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
  end

  // ****************************************
  // Power-down sequencing
  // ****************************************
  always_comb begin
    nxt_pd = pd_ff;
    nxt_arm_cnt = arm_cnt_ff;
    nxt_wake_any = wake_any_ff;
    nxt_half = cpu_run ? !half_ff : half_ff;
    case (pd_ff)
      pllpd_pkg::PD_RUN: begin
        if (csr_wr && (wr_field == pllpd_pkg::PD_CODE_HALT_EN || wr_field == pllpd_pkg::PD_CODE_HALT_ANY)) begin
          nxt_pd = pllpd_pkg::PD_ARM;
          nxt_arm_cnt = pllpd_pkg::PD1_CNT_LAST;
          nxt_wake_any = (wr_field == pllpd_pkg::PD_CODE_HALT_ANY);
        end else if (csr_wr && wr_field == pllpd_pkg::PD_CODE_PLL_OUT) begin
          nxt_pd = pllpd_pkg::PD_PLL_OUT;
        end else if (csr_wr && wr_field == pllpd_pkg::PD_CODE_PLL_IN) begin
          nxt_pd = pllpd_pkg::PD_PLL_IN;
        end
      end
      pllpd_pkg::PD_ARM: begin
        if (arm_cnt_ff == '0) nxt_pd = pllpd_pkg::PD_CPU_HALT;
        else nxt_arm_cnt = arm_cnt_ff - 3'h1;
      end
      // An enabled interrupt always wakes; any interrupt only when the field chose that
      pllpd_pkg::PD_CPU_HALT: begin
        if (irq_enabled_wake || (wake_any_ff && irq_any_wake)) nxt_pd = pllpd_pkg::PD_RUN;
      end
      // PLL halts ignore every interrupt
      pllpd_pkg::PD_PLL_OUT, pllpd_pkg::PD_PLL_IN: nxt_pd = pd_ff;
      default: nxt_pd = pllpd_pkg::PD_RUN;
    endcase
    if (!dev_rst_n_st) nxt_pd = pllpd_pkg::PD_RUN;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= pllpd_pkg::RESP_OKAY;
      rvalid_ff <= 1'b0;
      rresp_ff <= pllpd_pkg::RESP_OKAY;
      rdata_ff <= '0;
      field_ff <= pllpd_pkg::PD_CODE_NONE;
      pd_ff <= pllpd_pkg::PD_RUN;
      arm_cnt_ff <= '0;
      wake_any_ff <= 1'b0;
      half_ff <= 1'b0;
    end else if (clk_en) begin
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
      field_ff <= nxt_field;
      pd_ff <= nxt_pd;
      arm_cnt_ff <= nxt_arm_cnt;
      wake_any_ff <= nxt_wake_any;
      half_ff <= nxt_half;
    end
  end

  assign cpu_run = clk_ready && (pd_ff != pllpd_pkg::PD_PLL_OUT) && (pd_ff != pllpd_pkg::PD_PLL_IN);
  assign cpu_clock_output = cpu_run;
  assign half_rate_clock_output = half_ff;
  assign pll_multiply_factor = factor_ff;
  assign pll_bypass = bypass_ff;
  assign cpu_halt_mode = (pd_ff == pllpd_pkg::PD_CPU_HALT);
  assign pll_output_halt_mode = (pd_ff == pllpd_pkg::PD_PLL_OUT);
  assign pll_input_halt_mode = (pd_ff == pllpd_pkg::PD_PLL_IN);

  AST_STRAP_LOW_BYPASS: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (clk_en && !dev_rst_n_st && !strap_st) |=> (bypass_ff && factor_ff == pllpd_pkg::MULT_X1)) else $error("strap low not bypassed");
  AST_CFG_ZERO_BYPASS: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (clk_en && !dev_rst_n_st && bus_cfg == pllpd_pkg::CFG_BYPASS) |=> bypass_ff) else $error("zero config not bypassed");
  AST_BOOT_CAPTURE: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (clk_en && !dev_rst_n_st) |=> (boot_ff == $past(bus_st))) else $error("boot word not captured in reset");
  AST_HALT_DELAY: assert property (@(posedge clk_sys) disable iff (!arst_n || !dev_rst_n_st || !clk_en)
    $rose(pd_ff == pllpd_pkg::PD_ARM) |-> !cpu_halt_mode [*8] ##1 cpu_halt_mode) else $error("halt delay wrong");
  AST_PLL_HALT_HOLDS: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (clk_en && dev_rst_n_st && (pll_output_halt_mode || pll_input_halt_mode)) |=> $stable(pd_ff)) else $error("PLL halt left");
  AST_HALF_RATE: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (clk_en && cpu_run) |=> (half_ff != $past(half_ff))) else $error("half rate output did not toggle");
endmodule

// ==== dv/pllpd_board.sv ====
// Purpose: Board side of the block: the boot word on the data bus and the device reset source
// Assumes: The bench clock stands in for the reference oscillator
// Notes: Once reset ends, the bus shows the inverted word so late capture is caught
`timescale 1ns/1ps
module pllpd_board (
  // Bench control
  input wire logic clk_sys,
  input wire logic go,
  input wire logic [31:0] word,
  // Pins
  output logic device_reset_n,
  output logic [31:0] external_data_bus
);
  // ********
  // Reset source
  // ********
  assign external_data_bus = device_reset_n ? ~word : word;
  initial device_reset_n = 1'b1;
  // Every request gives a fresh falling edge so the PLL starts lock unless it is bypassed
  always @(posedge clk_sys) begin
    if (go) begin
      device_reset_n <= 1'b0;
      repeat (4) @(posedge clk_sys);
      device_reset_n <= 1'b1;
    end
  end
endmodule

// ==== dv/pllpd_top_tb.sv ====
// Purpose: Self-checking bench of clock mode and power-down control
// Assumes: Lock wait shortened by parameter
// Notes: One bus request in flight at a time
`timescale 1ns/1ps
module pllpd_top_tb;
  localparam int unsigned LW = 40;
  logic clk_sys = 0, arst_n = 0, go = 0, strap = 0, ie = 0, ia = 0, half, h1, h2, h3, byp, drst_n, cko;
  logic awv = 0, awr, wv = 0, wr, bv, brdy = 0, arv = 0, arr, rv, rrdy = 0;
  logic [7:0] aa = 0, ra = 0;
  logic [31:0] wd = 0, bw = 0, rd, edb, v;
  logic [1:0] br, rr, r;
  logic [3:0] mult;
  int n, fails = 0, comparisons = 0;
  pllpd_board i_board (.clk_sys(clk_sys), .go(go), .word(bw), .device_reset_n(drst_n), .external_data_bus(edb));
  pllpd_top #(.LOCK_WAIT_CYCLES(LW)) i_dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .clk_en(1'b1), .s_axi_awaddr(aa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'h3), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_araddr(ra), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrdy),
    .pll_enable_strap(strap), .device_reset_n(drst_n), .external_data_bus(edb), .irq_enabled_wake(ie),
    .irq_any_wake(ia), .cpu_clock_output(cko), .half_rate_clock_output(half), .pll_multiply_factor(mult),
    .pll_bypass(byp), .cpu_halt_mode(h1), .pll_output_halt_mode(h2), .pll_input_halt_mode(h3));
  // One fixed reference rate stands in for every factor's allowed range
  initial forever #5 clk_sys = ~clk_sys;
  // ********
  // Helpers
  // ********
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    if (fails == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Ready and valid are looked at on the falling edge, so the rising edge acts on settled values
  task automatic ax(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic at, wt, got;
    got = 0;
    n = 0;
    aa <= a;
    ra <= a;
    wd <= d;
    awv <= w;
    wv <= w;
    brdy <= w;
    arv <= !w;
    rrdy <= !w;
    repeat (50) if (!got) begin
      @(negedge clk_sys);
      at = awv && awr || arv && arr;
      wt = wv && wr;
      got = w ? bv : rv;
      v = rd;
      r = rr;
      @(posedge clk_sys);
      n++;
      if (wt) n = 0;
      awv <= awv && !at;
      arv <= arv && !at;
      wv <= wv && !wt;
    end
    brdy <= 0;
    rrdy <= 0;
  endtask
  task automatic dev_reset();
    go <= 1;
    @(posedge clk_sys);
    go <= 0;
    repeat (10) @(posedge clk_sys);
  endtask
  task automatic irq(input logic en);
    ie <= en;
    ia <= !en;
    @(posedge clk_sys);
    ie <= 0;
    ia <= 0;
    repeat (4) @(posedge clk_sys);
  endtask
  // ********
  // Scenarios
  // ********
  task automatic t_decode();
    logic [3:0] tab [8] = '{4'h1, 4'h4, 4'h8, 4'hA, 4'h6, 4'h9, 4'h7, 4'hB};
    for (int s = 0; s < 2; s++) begin
      for (int c = 0; c < 8; c++) begin
        strap <= s[0];
        bw <= 32'h1234_5678 | {c[2], 3'h0, c[1], 3'h0, c[0], 23'h0};
        dev_reset();
        check(mult, s ? tab[c] : 4'h1);
        check(byp, s == 0 || c == 0);
        ax(0, pllpd_pkg::ADDR_BOOT_WORD, 0);
        check(v, bw);
      end
    end
  endtask
  task automatic t_lock();
    logic p;
    int k;
    k = 0;
    bw <= 32'h0080_0000;
    dev_reset();
    ax(0, pllpd_pkg::ADDR_CLOCK_STATUS, 0);
    check(v[pllpd_pkg::ST_LOCKED], 0);
    check(cko, 0);
    repeat (LW) @(posedge clk_sys);
    ax(0, pllpd_pkg::ADDR_CLOCK_STATUS, 0);
    check(v[pllpd_pkg::ST_LOCKED], 1);
    check(cko, 1);
    @(negedge clk_sys);
    p = half;
    repeat (20) begin
      @(negedge clk_sys);
      k += int'(half !== p);
      p = half;
    end
    @(posedge clk_sys);
    check(k, 20);
  endtask
  task automatic t_pd(input logic [5:0] code);
    logic seen;
    logic [2:0] e;
    seen = 0;
    e = {code == pllpd_pkg::PD_CODE_PLL_IN, code == pllpd_pkg::PD_CODE_PLL_OUT,
      code == pllpd_pkg::PD_CODE_HALT_EN || code == pllpd_pkg::PD_CODE_HALT_ANY};
    // Whole field in one write with its top bit zero
    ax(1, pllpd_pkg::ADDR_CONTROL_STATUS, {16'h0, code, 10'h0});
    repeat (20) if (!seen) begin
      @(negedge clk_sys);
      seen = h1;
      @(posedge clk_sys);
      n += int'(!seen);
    end
    if (e[0]) check(n >= 8 && n <= 9, 1);
    check({h3, h2, h1}, e);
    irq(0);
    e[0] = e[0] && code == pllpd_pkg::PD_CODE_HALT_EN;
    check({h3, h2, h1}, e);
    irq(1);
    e[0] = 0;
    check({h3, h2, h1}, e);
    dev_reset();
    check({h3, h2, h1}, 0);
  endtask
  initial begin
    repeat (2) @(posedge clk_sys);
    arst_n <= 1;
    @(posedge clk_sys);
    t_decode();
    t_lock();
    t_pd(pllpd_pkg::PD_CODE_NONE);
    t_pd(pllpd_pkg::PD_CODE_HALT_EN);
    t_pd(pllpd_pkg::PD_CODE_HALT_ANY);
    t_pd(pllpd_pkg::PD_CODE_PLL_OUT);
    t_pd(pllpd_pkg::PD_CODE_PLL_IN);
    t_pd(6'h05);
    ax(0, 8'h40, 0);
    check(r, pllpd_pkg::RESP_SLVERR);
    final_report();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    final_report();
  end
endmodule
